// ===== src/bmc_consts.svh
`ifndef BMC_CONSTS_SVH
`define BMC_CONSTS_SVH
// Exact opcodes
`define BMC_OPC_CCL 16'h000D
`define BMC_OPC_CCE 16'h000E
`define BMC_OPC_CCG 16'h000F
`define BMC_OPC_LD_FRAME 16'h0010
`define BMC_OPC_LD_SP 16'h0011
`define BMC_OPC_LD_ENV 16'h0012
`define BMC_OPC_LD_PC 16'h0013
`define BMC_OPC_RD_ENV 16'h0014
`define BMC_OPC_RD_PC 16'h0015
`define BMC_OPC_CALL_DYN 16'h001A
`define BMC_OPC_XSUM_FAR 16'h00DB
`define BMC_OPC_XSUM_LOC 16'h00E3
`define BMC_OPC_CNT_REP 16'h00EE
`define BMC_OPC_MOVE_UP 16'h010F
`define BMC_OPC_MOVE_DN 16'h0110
`define BMC_OPC_MOVE_SUM 16'h0111
`define BMC_OPC_CMP 16'h0112
`define BMC_OPC_CODE_MAP 16'h012C
// Opcode groups: mask and match
`define BMC_MSK_LD_RP 16'hFFF8
`define BMC_OPC_LD_RP 16'h0040
`define BMC_MSK_IMM 16'hFE00
`define BMC_OPC_ADD_SP 16'h0400
`define BMC_OPC_CALL_LOC 16'h2E00
`define BMC_OPC_CALL_FAR 16'hAE00
// Machine state word fields
`define BMC_ENV_SUPERVISOR_FLAG 15
`define BMC_ENV_DS 13
`define BMC_ENV_CS 12
`define BMC_ENV_LS 11
`define BMC_ENV_N 4
`define BMC_ENV_Z 3
// Reset values
`define BMC_ENV_RESET 16'h8000
`define BMC_REG_RESET 16'h0000
// Limits, sizes and maps
`define BMC_SP_LIMIT 17'h07FFF
`define BMC_MARK_WORDS 17'h00003
`define BMC_DATA_MAP 4'h0
`define BMC_MAP_USER 4'h2
`define BMC_MAP_EXT 4'h5
`define BMC_XEP_TOP 16'hFFFF
`define BMC_POP_MOVE 3'h5
`define BMC_POP_XLOC 3'h2
`define BMC_POP_XFAR 3'h3
`endif

// ===== src/bmc_pkg.sv
package bmc_pkg;
  // Sequencer states, one-hot
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001, ST_STEP = 10'h002, ST_RD1 = 10'h004, ST_RD2 = 10'h008,
    ST_WR = 10'h010, ST_MARK = 10'h020, ST_XEP = 10'h040, ST_TAB1 = 10'h080,
    ST_TAB2 = 10'h100, ST_TAB3 = 10'h200
  } bmc_state_t;
  // Decoded instruction
  typedef enum logic [4:0] {
    OP_NONE, OP_CNT_REP, OP_MOVE_UP, OP_MOVE_DN, OP_MOVE_SUM, OP_CMP, OP_XSUM_LOC,
    OP_XSUM_FAR, OP_LD_FRAME, OP_LD_SP, OP_LD_ENV, OP_LD_PC, OP_RD_ENV, OP_RD_PC,
    OP_LD_RP, OP_ADD_SP, OP_CC, OP_CALL_LOC, OP_CALL_FAR, OP_CALL_DYN, OP_CODE_MAP
  } bmc_op_t;
  // Memory command carried with MEM_REQ
  typedef struct packed {
    logic we;
    logic byte_sel;
    logic [31:0] addr;
    logic [15:0] wdata;
  } bmc_mem_cmd_t;
endpackage : bmc_pkg

// ===== src/bmc_fifo.sv
`timescale 1ns/100ps
module bmc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Storage words
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] fill_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  // Honest flags from the fill count
  assign in_ready = fill_r != (AW+1)'(DEPTH);
  assign out_valid = fill_r != '0;
  assign out_data = mem_r[rd_ptr_r];
  // Pointers wrap at DEPTH, so DEPTH need not be a power of two
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      fill_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      fill_r <= fill_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Data array, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
endmodule : bmc_fifo

// ===== src/bmc_unit.sv
`timescale 1ns/100ps
`include "bmc_consts.svh"
// Notes on behaviour
// - Duplicate count walks words, counts into A
// - Compare with word two bytes below
// - Forward far byte move, count down
// - Reverse byte move; moves pop five words
// - Move with checksum in F, pop five
// - Far byte compare stops on mismatch/zero
// - Mismatch sets greater or less condition
// - Exhausted compare sets equal, count zero
// - Loop ops pause per step, state kept
// - Local word XOR sum, drop two
// - Far word XOR sum, drop three
// - Load frame base or counter, pop
// - Load stack pointer, overflow above 32767
// - Low byte replaced, high byte ANDed
// - Register pointer from instruction field
// - Signed immediate added to stack pointer
// - Condition code set less/equal/greater
// - Call pushes marker, checks entry legality unless supervisor
// - Frame and stack at S+3, load P
// - Far call resolves through external table
// - Code map is LS*2+CS+2
// - Dynamic call map 2..5, else 2
module bmc_unit #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR_WORD,
  output logic INSTR_READY,
  input wire logic PUSH_VALID,
  input wire logic [15:0] PUSH_DATA,
  input wire logic IRQ_PENDING,
  output logic DONE,
  output logic SUSPENDED,
  output logic TRAP_OVERFLOW,
  output logic TRAP_FAIL,
  output logic [15:0] STACK_TOP,
  output logic [15:0] PROG_COUNTER,
  output logic [15:0] FRAME_BASE,
  output logic [15:0] STACK_PTR,
  output logic [15:0] MACHINE_STATE,
  output logic MEM_REQ,
  output bmc_pkg::bmc_mem_cmd_t MEM_CMD,
  input wire logic MEM_ACK,
  input wire logic [15:0] MEM_RDATA
);
  // Stack slot k below the top
  function automatic logic [2:0] slot(input logic [2:0] ptr, input logic [2:0] k);
    slot = ptr - k;
  endfunction : slot
  // Byte address of a word in a map
  function automatic logic [31:0] word_addr(input logic [3:0] map, input logic [15:0] w);
    word_addr = {11'h000, map, w, 1'b0};
  endfunction : word_addr
  // Only maps 2..5 are legal call targets
  function automatic logic [3:0] norm_map(input logic [3:0] m);
    norm_map = (m >= `BMC_MAP_USER && m <= `BMC_MAP_EXT) ? m : `BMC_MAP_USER;
  endfunction : norm_map
  // Instruction decode
  function automatic bmc_pkg::bmc_op_t decode(input logic [15:0] w);
    if (w == `BMC_OPC_CNT_REP) decode = bmc_pkg::OP_CNT_REP;
    else if (w == `BMC_OPC_MOVE_UP) decode = bmc_pkg::OP_MOVE_UP;
    else if (w == `BMC_OPC_MOVE_DN) decode = bmc_pkg::OP_MOVE_DN;
    else if (w == `BMC_OPC_MOVE_SUM) decode = bmc_pkg::OP_MOVE_SUM;
    else if (w == `BMC_OPC_CMP) decode = bmc_pkg::OP_CMP;
    else if (w == `BMC_OPC_XSUM_LOC) decode = bmc_pkg::OP_XSUM_LOC;
    else if (w == `BMC_OPC_XSUM_FAR) decode = bmc_pkg::OP_XSUM_FAR;
    else if (w == `BMC_OPC_LD_FRAME) decode = bmc_pkg::OP_LD_FRAME;
    else if (w == `BMC_OPC_LD_SP) decode = bmc_pkg::OP_LD_SP;
    else if (w == `BMC_OPC_LD_ENV) decode = bmc_pkg::OP_LD_ENV;
    else if (w == `BMC_OPC_LD_PC) decode = bmc_pkg::OP_LD_PC;
    else if (w == `BMC_OPC_RD_ENV) decode = bmc_pkg::OP_RD_ENV;
    else if (w == `BMC_OPC_RD_PC) decode = bmc_pkg::OP_RD_PC;
    else if (w == `BMC_OPC_CALL_DYN) decode = bmc_pkg::OP_CALL_DYN;
    else if (w == `BMC_OPC_CODE_MAP) decode = bmc_pkg::OP_CODE_MAP;
    else if (w >= `BMC_OPC_CCL && w <= `BMC_OPC_CCG) decode = bmc_pkg::OP_CC;
    else if ((w & `BMC_MSK_LD_RP) == `BMC_OPC_LD_RP) decode = bmc_pkg::OP_LD_RP;
    else if ((w & `BMC_MSK_IMM) == `BMC_OPC_ADD_SP) decode = bmc_pkg::OP_ADD_SP;
    else if ((w & `BMC_MSK_IMM) == `BMC_OPC_CALL_LOC) decode = bmc_pkg::OP_CALL_LOC;
    else if ((w & `BMC_MSK_IMM) == `BMC_OPC_CALL_FAR) decode = bmc_pkg::OP_CALL_FAR;
    else decode = bmc_pkg::OP_NONE;
  endfunction : decode

  bmc_pkg::bmc_state_t state_r, state_nxt; // Sequencer
  bmc_pkg::bmc_op_t op_r; // Instruction in progress
  logic [15:0] iw_r; // Its instruction word
  logic [15:0] stk_r [8]; // Register stack
  logic [15:0] p_r, l_r, s_r, env_r, env_nxt; // Program registers
  logic [15:0] tmp_r; // First operand of a two-read step
  logic [1:0] cnt_r; // Marker word index
  logic [3:0] map_r; // Code map of the call target
  logic [8:0] pep_r; // Entry number of the call target
  logic stepped_r; // At least one step done since issue
  logic done_r, susp_r, tovf_r, tfail_r; // Result pulses
  logic fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out;

  wire [2:0] rp = env_r[2:0];
  wire [15:0] a = stk_r[rp];
  wire [15:0] b = stk_r[slot(rp, 3'h1)];
  wire [15:0] c = stk_r[slot(rp, 3'h2)];
  wire [15:0] d = stk_r[slot(rp, 3'h3)];
  wire [15:0] e = stk_r[slot(rp, 3'h4)];
  wire [15:0] f = stk_r[slot(rp, 3'h5)];
  wire [31:0] src_addr = {c, b};
  wire [31:0] dst_addr = {e, d};
  wire [31:0] dup_addr = {d, c};

  // State and op classes
  wire st_idle = state_r == bmc_pkg::ST_IDLE;
  wire st_step = state_r == bmc_pkg::ST_STEP;
  wire st_rd1 = state_r == bmc_pkg::ST_RD1;
  wire st_rd2 = state_r == bmc_pkg::ST_RD2;
  wire st_wr = state_r == bmc_pkg::ST_WR;
  wire st_mark = state_r == bmc_pkg::ST_MARK;
  wire st_xep = state_r == bmc_pkg::ST_XEP;
  wire st_tab1 = state_r == bmc_pkg::ST_TAB1;
  wire st_tab2 = state_r == bmc_pkg::ST_TAB2;
  wire st_tab3 = state_r == bmc_pkg::ST_TAB3;
  wire is_cnt = op_r == bmc_pkg::OP_CNT_REP;
  wire is_down = op_r == bmc_pkg::OP_MOVE_DN;
  wire is_sum = op_r == bmc_pkg::OP_MOVE_SUM;
  wire is_move = (op_r == bmc_pkg::OP_MOVE_UP) | is_down | is_sum;
  wire is_cmp = op_r == bmc_pkg::OP_CMP;
  wire is_xloc = op_r == bmc_pkg::OP_XSUM_LOC;
  wire is_xfar = op_r == bmc_pkg::OP_XSUM_FAR;
  wire is_loop = is_cnt | is_move | is_cmp | is_xloc | is_xfar;
  wire is_far = op_r == bmc_pkg::OP_CALL_FAR;
  wire is_dyn = op_r == bmc_pkg::OP_CALL_DYN;
  wire is_call = is_far | is_dyn | (op_r == bmc_pkg::OP_CALL_LOC);
  wire supervisor_flag = env_r[`BMC_ENV_SUPERVISOR_FLAG];

  // Handshakes
  wire push_take = st_idle & PUSH_VALID;
  wire instr_take = st_idle & INSTR_VALID & ~PUSH_VALID;
  wire mem_ack = MEM_REQ & MEM_ACK;
  wire count_zero = is_cnt ? (b == 16'h0000) : (a == 16'h0000);
  // pause only between steps, never before the first
  wire pause = st_step & is_loop & ~count_zero & stepped_r & IRQ_PENDING;
  wire loop_end = st_step & is_loop & count_zero;
  wire exec_now = st_step & ~is_loop & ~is_call;
  wire rd1_ack = st_rd1 & mem_ack;
  wire rd2_ack = st_rd2 & mem_ack;
  wire wr_ack = st_wr & mem_ack;
  wire words_same = tmp_r == MEM_RDATA;
  wire bytes_same = tmp_r[7:0] == MEM_RDATA[7:0];
  wire cmp_stop = rd2_ack & is_cmp & ~bytes_same;
  wire pep_legal = ({7'h00, pep_r} >= tmp_r) && ({7'h00, pep_r} < MEM_RDATA);
  wire call_bad = st_tab2 & mem_ack & ~pep_legal;
  wire call_ok = st_tab3 & mem_ack;
  wire [2:0] pop_n = is_move ? `BMC_POP_MOVE : is_xloc ? `BMC_POP_XLOC :
                     is_xfar ? `BMC_POP_XFAR : 3'h0;
  wire [3:0] cur_map = {2'b00, env_r[`BMC_ENV_LS], 1'b0} + {3'b000, env_r[`BMC_ENV_CS]}
                       + `BMC_MAP_USER;
  // dynamic call map from A bits 12..15, entry from bits 0..8
  wire [3:0] dyn_map = norm_map(a[15:12]);
  wire [31:0] step_inc = is_down ? 32'hFFFF_FFFF : 32'h0000_0001;
  wire [16:0] add_to_stack_ptr_sum = {1'b0, s_r} + {{9{iw_r[7]}}, iw_r[7:0]};
  wire add_to_stack_ptr_ovf = ~add_to_stack_ptr_sum[16] & add_to_stack_ptr_sum[15];
  wire [16:0] s_plus3 = {1'b0, s_r} + `BMC_MARK_WORDS;

  // Memory request selection
  wire [31:0] rd1_addr = is_cnt ? dup_addr - 32'h0000_0002 :
                         is_xloc ? word_addr(`BMC_DATA_MAP, b) : src_addr;
  wire [31:0] rd2_addr = is_cnt ? dup_addr : dst_addr;
  wire [15:0] mark_word = (cnt_r == 2'h0) ? p_r : (cnt_r == 2'h1) ? env_r : l_r;
  wire [15:0] mark_off = s_r + {14'h0000, cnt_r} + 16'h0001;
  wire [31:0] tab_addr = st_xep ? word_addr(cur_map, `BMC_XEP_TOP - {7'h00, pep_r}) :
                         st_tab1 ? word_addr(map_r, 16'h0000) :
                         st_tab2 ? word_addr(map_r, 16'h0001) :
                         word_addr(map_r, {7'h00, pep_r});
  assign MEM_REQ = (st_rd1 & (~is_move | fifo_in_ready)) | st_rd2 | (st_wr & fifo_out_valid)
                   | st_mark | st_xep | st_tab1 | st_tab2 | st_tab3;
  assign MEM_CMD.we = st_wr | st_mark;
  assign MEM_CMD.byte_sel = (st_rd1 | st_rd2 | st_wr) & (is_move | is_cmp);
  assign MEM_CMD.addr = st_rd1 ? rd1_addr : st_rd2 ? rd2_addr : st_wr ? dst_addr :
                        st_mark ? word_addr(`BMC_DATA_MAP, mark_off) : tab_addr;
  assign MEM_CMD.wdata = st_wr ? {8'h00, fifo_out} : mark_word;

  // Moved bytes queue here; the write side stalls the read side when full
  bmc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLOCK),
    .srst(SRST),
    .in_valid(rd1_ack & is_move),
    .in_ready(fifo_in_ready),
    .in_data(MEM_RDATA[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(wr_ack),
    .out_data(fifo_out)
  );

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bmc_pkg::ST_IDLE: begin
        if (instr_take) state_nxt = bmc_pkg::ST_STEP;
      end
      bmc_pkg::ST_STEP: begin
        if (is_call) state_nxt = bmc_pkg::ST_MARK;
        else if (~is_loop | count_zero | pause) state_nxt = bmc_pkg::ST_IDLE;
        else state_nxt = bmc_pkg::ST_RD1;
      end
      bmc_pkg::ST_RD1: begin
        if (mem_ack) begin
          state_nxt = is_move ? bmc_pkg::ST_WR :
                      (is_xloc | is_xfar) ? bmc_pkg::ST_STEP : bmc_pkg::ST_RD2;
        end
      end
      bmc_pkg::ST_RD2: begin
        // a mismatch ends the count with B and address left on it
        if (mem_ack) begin
          state_nxt = (is_cnt ? words_same : bytes_same) ? bmc_pkg::ST_STEP : bmc_pkg::ST_IDLE;
        end
      end
      bmc_pkg::ST_WR: begin
        if (mem_ack) state_nxt = bmc_pkg::ST_STEP;
      end
      bmc_pkg::ST_MARK: begin
        if (mem_ack && cnt_r == 2'h2) begin
          state_nxt = is_far ? bmc_pkg::ST_XEP : supervisor_flag ? bmc_pkg::ST_TAB3 : bmc_pkg::ST_TAB1;
        end
      end
      bmc_pkg::ST_XEP: begin
        if (mem_ack) state_nxt = supervisor_flag ? bmc_pkg::ST_TAB3 : bmc_pkg::ST_TAB1;
      end
      bmc_pkg::ST_TAB1: begin
        if (mem_ack) state_nxt = bmc_pkg::ST_TAB2;
      end
      bmc_pkg::ST_TAB2: begin
        // illegal entry for an unprivileged caller fails here
        if (mem_ack) state_nxt = pep_legal ? bmc_pkg::ST_TAB3 : bmc_pkg::ST_IDLE;
      end
      bmc_pkg::ST_TAB3: begin
        if (mem_ack) state_nxt = bmc_pkg::ST_IDLE;
      end
      default: state_nxt = bmc_pkg::ST_IDLE;
    endcase
  end

  // Sequencer registers and result pulses
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state_r <= bmc_pkg::ST_IDLE;
      op_r <= bmc_pkg::OP_NONE;
      iw_r <= 16'h0000;
      stepped_r <= 1'b0;
      done_r <= 1'b0;
      susp_r <= 1'b0;
      tfail_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (instr_take) begin
        op_r <= decode(INSTR_WORD);
        iw_r <= INSTR_WORD;
      end
      stepped_r <= instr_take ? 1'b0 : (stepped_r | rd1_ack);
      // pause reports SUSPENDED instead of DONE
      susp_r <= pause;
      done_r <= ~st_idle & (state_nxt == bmc_pkg::ST_IDLE) & ~pause;
      tfail_r <= call_bad;
    end
  end

  // Step scratch and call target
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      tmp_r <= 16'h0000;
      cnt_r <= 2'h0;
      map_r <= `BMC_MAP_USER;
      pep_r <= 9'h000;
    end else begin
      if (rd1_ack | (st_tab1 & mem_ack)) tmp_r <= MEM_RDATA;
      if (st_step) cnt_r <= 2'h0;
      else if (st_mark & mem_ack) cnt_r <= cnt_r + 2'h1;
      if (st_step & is_call) begin
        map_r <= is_dyn ? dyn_map : cur_map;
        pep_r <= is_dyn ? a[8:0] : iw_r[8:0];
      end else if (st_xep & mem_ack) begin
        // external entry names map and entry slot
        map_r <= norm_map(MEM_RDATA[15:12]);
        pep_r <= MEM_RDATA[8:0];
      end
    end
  end

  // Machine state word next value
  always_comb begin
    env_nxt = env_r;
    if (push_take) env_nxt[2:0] = rp + 3'h1;
    if (loop_end) env_nxt[2:0] = rp - pop_n;
    if (loop_end & is_cmp) begin
      env_nxt[`BMC_ENV_N] = 1'b0;
      env_nxt[`BMC_ENV_Z] = 1'b1;
    end
    if (cmp_stop) begin
      env_nxt[`BMC_ENV_N] = MEM_RDATA[7:0] < tmp_r[7:0];
      env_nxt[`BMC_ENV_Z] = 1'b0;
    end
    if (exec_now) begin
      case (op_r)
        bmc_pkg::OP_LD_FRAME, bmc_pkg::OP_LD_SP, bmc_pkg::OP_LD_PC: env_nxt[2:0] = rp - 3'h1;
        bmc_pkg::OP_RD_ENV, bmc_pkg::OP_RD_PC: env_nxt[2:0] = rp + 3'h1;
        bmc_pkg::OP_LD_ENV: env_nxt = {env_r[15:8] & a[15:8], a[7:0]};
        bmc_pkg::OP_LD_RP: env_nxt[2:0] = iw_r[2:0];
        // condition code from low opcode bits
        bmc_pkg::OP_CC: begin
          env_nxt[`BMC_ENV_N] = iw_r[1:0] == 2'b01;
          env_nxt[`BMC_ENV_Z] = iw_r[1:0] == 2'b10;
        end
        default: env_nxt = env_r;
      endcase
    end
    // dynamic call pops A and selects code and library space
    if (call_ok & is_dyn) begin
      env_nxt[2:0] = rp - 3'h1;
      env_nxt[`BMC_ENV_CS] = (map_r == 4'h3) | (map_r == 4'h5);
      env_nxt[`BMC_ENV_LS] = (map_r == 4'h4) | (map_r == 4'h5);
    end
  end

  // Program registers and overflow trap
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      env_r <= `BMC_ENV_RESET;
      p_r <= `BMC_REG_RESET;
      l_r <= `BMC_REG_RESET;
      s_r <= `BMC_REG_RESET;
      tovf_r <= 1'b0;
    end else begin
      env_r <= env_nxt;
      tovf_r <= 1'b0;
      if (exec_now & (op_r == bmc_pkg::OP_LD_FRAME)) l_r <= a;
      if (exec_now & (op_r == bmc_pkg::OP_LD_PC)) p_r <= a;
      // load stack pointer, trap on bit 15
      if (exec_now & (op_r == bmc_pkg::OP_LD_SP)) begin
        s_r <= a;
        tovf_r <= a[15];
      end
      if (exec_now & (op_r == bmc_pkg::OP_ADD_SP)) begin
        s_r <= add_to_stack_ptr_sum[15:0];
        tovf_r <= add_to_stack_ptr_ovf;
      end
      if (call_ok) begin
        l_r <= s_plus3[15:0];
        s_r <= s_plus3[15:0];
        p_r <= MEM_RDATA;
        tovf_r <= s_plus3 > `BMC_SP_LIMIT;
      end
    end
  end

  // Register stack contents
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      for (int i = 0; i < 8; i++) begin
        stk_r[i] <= 16'h0000;
      end
    end else begin
      if (push_take) stk_r[slot(rp, 3'h7)] <= PUSH_DATA;
      if (exec_now & (op_r == bmc_pkg::OP_RD_ENV)) stk_r[slot(rp, 3'h7)] <= env_r;
      if (exec_now & (op_r == bmc_pkg::OP_RD_PC)) stk_r[slot(rp, 3'h7)] <= p_r;
      // map number into A bits 12..15
      if (exec_now & (op_r == bmc_pkg::OP_CODE_MAP)) stk_r[rp] <= {cur_map, a[11:0]};
      if (rd1_ack & is_xloc) begin
        stk_r[rp] <= a - 16'h0001;
        stk_r[slot(rp, 3'h1)] <= b + 16'h0001;
        stk_r[slot(rp, 3'h2)] <= c ^ MEM_RDATA;
      end
      if (rd1_ack & is_xfar) begin
        stk_r[rp] <= a - 16'h0001;
        {stk_r[slot(rp, 3'h2)], stk_r[slot(rp, 3'h1)]} <= src_addr + 32'h0000_0002;
        stk_r[slot(rp, 3'h3)] <= d ^ MEM_RDATA;
      end
      // each duplicate bumps A and walks on
      if (rd2_ack & is_cnt & words_same) begin
        stk_r[rp] <= a + 16'h0001;
        stk_r[slot(rp, 3'h1)] <= b - 16'h0001;
        {stk_r[slot(rp, 3'h3)], stk_r[slot(rp, 3'h2)]} <= dup_addr + 32'h0000_0002;
      end
      if (rd2_ack & is_cmp & bytes_same) begin
        stk_r[rp] <= a - 16'h0001;
        {stk_r[slot(rp, 3'h2)], stk_r[slot(rp, 3'h1)]} <= src_addr + 32'h0000_0001;
        {stk_r[slot(rp, 3'h4)], stk_r[slot(rp, 3'h3)]} <= dst_addr + 32'h0000_0001;
      end
      // byte written, addresses step, count falls
      if (wr_ack) begin
        stk_r[rp] <= a - 16'h0001;
        {stk_r[slot(rp, 3'h2)], stk_r[slot(rp, 3'h1)]} <= src_addr + step_inc;
        {stk_r[slot(rp, 3'h4)], stk_r[slot(rp, 3'h3)]} <= dst_addr + step_inc;
        // byte folds into the low byte
        if (is_sum) stk_r[slot(rp, 3'h5)] <= f ^ {8'h00, fifo_out};
      end
    end
  end

  // Outputs
  assign INSTR_READY = st_idle & ~PUSH_VALID;
  assign DONE = done_r;
  assign SUSPENDED = susp_r;
  assign TRAP_OVERFLOW = tovf_r;
  assign TRAP_FAIL = tfail_r;
  assign STACK_TOP = a;
  assign PROG_COUNTER = p_r;
  assign FRAME_BASE = l_r;
  assign STACK_PTR = s_r;
  assign MACHINE_STATE = env_r;
endmodule : bmc_unit

// ===== tb/bmc_unit_props.sv
`timescale 1ns/100ps
`include "bmc_consts.svh"
// Port-level timing checks of the unit
module bmc_unit_props (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR_WORD,
  input wire logic INSTR_READY,
  input wire logic DONE,
  input wire logic TRAP_OVERFLOW,
  input wire logic [15:0] STACK_TOP,
  input wire logic [15:0] PROG_COUNTER,
  input wire logic [15:0] FRAME_BASE,
  input wire logic [15:0] MACHINE_STATE,
  input wire logic MEM_REQ,
  input wire bmc_pkg::bmc_mem_cmd_t MEM_CMD,
  input wire logic MEM_ACK
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  // Instruction accepted at this edge
  wire take = INSTR_VALID && INSTR_READY;
  property p_cc_less; take && INSTR_WORD == `BMC_OPC_CCL |-> ##2 DONE && MACHINE_STATE[4:3] == 2'b10; endproperty
  a_cc_less: assert property (p_cc_less) else $error("less code wrong");
  property p_cc_eq; take && INSTR_WORD == `BMC_OPC_CCE |-> ##2 DONE && MACHINE_STATE[4:3] == 2'b01; endproperty
  a_cc_eq: assert property (p_cc_eq) else $error("equal code wrong");
  property p_ld_frame; take && INSTR_WORD == `BMC_OPC_LD_FRAME |-> ##2 FRAME_BASE == $past(STACK_TOP, 2); endproperty
  a_ld_frame: assert property (p_ld_frame) else $error("frame base not loaded");
  property p_ld_pc; take && INSTR_WORD == `BMC_OPC_LD_PC |-> ##2 PROG_COUNTER == $past(STACK_TOP, 2); endproperty
  a_ld_pc: assert property (p_ld_pc) else $error("counter not loaded");
  property p_ld_env; take && INSTR_WORD == `BMC_OPC_LD_ENV |-> ##2 MACHINE_STATE == ($past(STACK_TOP, 2) & ($past(MACHINE_STATE, 2) | 16'h00FF)); endproperty
  a_ld_env: assert property (p_ld_env) else $error("state word load wrong");
  property p_sp_trap; take && INSTR_WORD == `BMC_OPC_LD_SP && STACK_TOP > 16'h7FFF |-> ##[1:3] TRAP_OVERFLOW; endproperty
  a_sp_trap: assert property (p_sp_trap) else $error("no overflow trap");
  property p_rp; take && (INSTR_WORD & `BMC_MSK_LD_RP) == `BMC_OPC_LD_RP |-> ##2 MACHINE_STATE[2:0] == $past(INSTR_WORD[2:0], 2); endproperty
  a_rp: assert property (p_rp) else $error("pointer field wrong");
  property p_map; take && INSTR_WORD == `BMC_OPC_CODE_MAP && MACHINE_STATE[12:11] == 2'b00 |-> ##2 STACK_TOP[15:12] == 4'h2; endproperty
  a_map: assert property (p_map) else $error("code map wrong");
  property p_hold; MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_CMD); endproperty
  a_hold: assert property (p_hold) else $error("memory request dropped");
endmodule : bmc_unit_props
bind bmc_unit bmc_unit_props u_props (.*);

// ===== tb/bmc_mem_model.sv
`timescale 1ns/100ps
// Byte-wide memory with random latency, words high byte first
module bmc_mem_model (
  input wire logic clk,
  input wire logic req,
  input wire bmc_pkg::bmc_mem_cmd_t cmd,
  output logic ack,
  output logic [15:0] rdata
);
  logic [7:0] bytes [logic [31:0]]; // Sparse store
  int wait_n = 0; // Stall cycles left
  // Answer after 0..2 cycles; idle data lines churn so stale values never pass
  always @(posedge clk) begin
    #1;
    ack = 0;
    rdata = $random;
    if (req && wait_n > 0) wait_n--;
    else if (req) begin
      ack = 1;
      wait_n = {$random} % 3;
      if (cmd.we && cmd.byte_sel) bytes[cmd.addr] = cmd.wdata[7:0];
      else if (cmd.we) {bytes[cmd.addr], bytes[cmd.addr + 1]} = cmd.wdata;
      else if (cmd.byte_sel) rdata = {8'h00, bytes[cmd.addr]};
      else rdata = {bytes[cmd.addr], bytes[cmd.addr + 1]};
    end
  end
endmodule : bmc_mem_model

// ===== tb/tb_top.sv
`timescale 1ns/100ps
`include "bmc_consts.svh"
module tb_top;
  localparam logic [31:0] SRC = 32'h0002_0100; // Source buffer
  localparam logic [31:0] DST = 32'h0003_0200; // Target buffer
  logic CLOCK = 0, SRST = 1, INSTR_VALID = 0, PUSH_VALID = 0, IRQ_PENDING = 0;
  logic [15:0] INSTR_WORD = 0, PUSH_DATA = 0, STACK_TOP, PROG_COUNTER, FRAME_BASE, STACK_PTR;
  logic [15:0] MACHINE_STATE, MEM_RDATA, s, x;
  logic INSTR_READY, DONE, SUSPENDED, TRAP_OVERFLOW, TRAP_FAIL, MEM_REQ, MEM_ACK;
  bmc_pkg::bmc_mem_cmd_t MEM_CMD;
  logic [19:0] exp_q [$], ev; // Notes {check top, check code, code, top}
  logic [1:0] cct [3] = '{2'b10, 2'b01, 2'b00}; // Less, equal, greater
  logic [15:0] ops [3] = '{`BMC_OPC_MOVE_UP, `BMC_OPC_MOVE_DN, `BMC_OPC_MOVE_SUM};
  integer seed = 32'he20cdf06;
  int failures = 0, tests_run = 0, n, m, k, j;
  bmc_unit dut (.*);
  bmc_mem_model u_mem (.clk(CLOCK), .req(MEM_REQ), .cmd(MEM_CMD), .ack(MEM_ACK), .rdata(MEM_RDATA));
  always #50 CLOCK = ~CLOCK;
  task chk(input string what, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // Strobe stays up between pushes; run lowers it
  task push(input logic [15:0] w);
    PUSH_VALID = 1;
    PUSH_DATA = w;
    @(posedge CLOCK);
    #1;
  endtask : push
  task pushx(input logic [31:0] a);
    push(a[31:16]);
    push(a[15:0]);
  endtask : pushx
  // Issue, reissuing after each pause, random interrupt requests meanwhile
  task run(input logic [15:0] op, input logic [19:0] e);
    int t;
    exp_q.push_back(e);
    PUSH_VALID = 0;
    do begin
      INSTR_VALID = 1;
      INSTR_WORD = op;
      do @(posedge CLOCK); while (INSTR_READY !== 1'b1);
      #1;
      INSTR_VALID = 0;
      t = 0;
      while (DONE !== 1'b1 && SUSPENDED !== 1'b1 && t < 400) begin
        IRQ_PENDING = ($random(seed) & 3) == 0;
        @(posedge CLOCK);
        #1;
        t++;
      end
      IRQ_PENDING = 0;
    end while (SUSPENDED === 1'b1);
    if (t >= 400) failures++;
  endtask : run
  // Oldest note against each finished instruction
  always @(negedge CLOCK) begin
    if (DONE === 1'b1) begin
      ev = exp_q.pop_front();
      if (ev[19]) chk("stack top", ev[15:0], STACK_TOP);
      if (ev[18]) chk("cond code", {14'h0, ev[17:16]}, {14'h0, MACHINE_STATE[4:3]});
    end
  end
  task end_sim;
    $display("Comparisons %0d, failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  initial begin
    #5000000;
    failures++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge CLOCK);
    #1;
    SRST = 0;
    chk("state word", 16'h8000, MACHINE_STATE);
    // Byte moves up, down and summed
    for (k = 0; k < 3; k++) begin
      n = 1 + {$random(seed)} % 6;
      s = $random(seed);
      x = s;
      for (j = 0; j < n; j++) begin
        u_mem.bytes[SRC + j] = $random(seed);
        x[7:0] ^= u_mem.bytes[SRC + j];
      end
      m = (k == 1) ? n - 1 : 0;
      push(s);
      pushx(DST + m);
      pushx(SRC + m);
      push(n[15:0]);
      run(ops[k], {4'h8, (k == 2) ? x : s});
      for (j = 0; j < n; j++) chk("byte", u_mem.bytes[SRC + j], u_mem.bytes[DST + j]);
    end
    // Compare: exhausted, target greater, target less
    for (k = 0; k < 3; k++) begin
      n = 2 + {$random(seed)} % 5;
      m = {$random(seed)} % n;
      for (j = 0; j < n; j++) begin
        u_mem.bytes[SRC + j] = $random(seed);
        u_mem.bytes[DST + j] = u_mem.bytes[SRC + j];
      end
      if (k > 0) u_mem.bytes[SRC + m] = 8'h80;
      if (k > 0) u_mem.bytes[DST + m] = (k == 1) ? 8'hC0 : 8'h10;
      pushx(DST);
      pushx(SRC);
      push(n[15:0]);
      run(`BMC_OPC_CMP, {2'b11, cct[(k + 1) % 3], (k == 0) ? 16'h0 : 16'(n - m)});
    end
    s = $random(seed);
    x = s;
    n = 1 + {$random(seed)} % 5;
    for (j = 0; j < n; j++) begin
      u_mem.bytes['h100 + 2 * j] = $random(seed);
      u_mem.bytes['h100 + 2 * j + 1] = u_mem.bytes['h100 + 2 * j];
      x ^= {2{u_mem.bytes['h100 + 2 * j]}};
    end
    push(s);
    pushx('h100);
    push(n[15:0]);
    run(`BMC_OPC_XSUM_FAR, {4'h8, x});
    push(s);
    push(16'h0080);
    push(n[15:0]);
    run(`BMC_OPC_XSUM_LOC, {4'h8, x});
    // Run of k repeats, then a change
    k = {$random(seed)} % 4;
    for (j = 0; j < 12; j++) u_mem.bytes[SRC + j] = (j <= 2 * k + 1) ? 8'h3C : 8'hC3;
    pushx(SRC + 2);
    push(16'h0005);
    push(s);
    run(`BMC_OPC_CNT_REP, {4'h8, s + 16'(k)});
    push(16'h1234);
    for (k = 0; k < 3; k++) run(16'(`BMC_OPC_CCL + k), {2'b11, cct[k], 16'h1234});
    run(`BMC_OPC_CODE_MAP, {4'h8, 16'h2234});
    push(s);
    run(`BMC_OPC_LD_FRAME, {4'h8, 16'h2234});
    chk("frame base", s, FRAME_BASE);
    push(~s);
    run(`BMC_OPC_LD_PC, {4'h8, 16'h2234});
    run(`BMC_OPC_RD_PC, {4'h8, ~s});
    push(16'h8000);
    run(`BMC_OPC_LD_SP, {4'h8, ~s});
    chk("stack ptr", 16'h8000, STACK_PTR);
    run(16'h04F0, 20'h0);
    chk("stack ptr", 16'h7FF0, STACK_PTR);
    run(16'h0043, 20'h0);
    push(16'h7FE0);
    run(`BMC_OPC_LD_ENV, 20'h0);
    run(`BMC_OPC_RD_ENV, {4'h8, 16'h00E0});
    #100;
    end_sim();
  end
endmodule : tb_top
